// file: asr_pkg.sv
package asr_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned FILT_REJECT_NS  = 50;
    localparam int unsigned FILT_CYC        = (FILT_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FLASH_INIT_NS   = 1000000;
    localparam int unsigned FLASH_INIT_CYC  = FLASH_INIT_NS / CLK_PERIOD_NS;
    localparam int unsigned EXT_TCL_MIN     = 3;
    localparam int unsigned EXT_TCL_MAX     = 8;
    localparam int unsigned FLASH_BLANK_CYC = 16;

    // Widths
    localparam int unsigned CFG_W   = 16;
    localparam int unsigned ADDR_W  = 24;
    localparam int unsigned DATA_W  = 16;

    // Values after reset and forced answers
    localparam logic [CFG_W-1:0]  CFG_RESET_VAL    = 16'hffff;
    localparam logic [ADDR_W-1:0] RESET_FETCH_ADDR = 24'h000000;
    localparam logic [DATA_W-1:0] FLASH_BLANK_VAL  = 16'hffff;
    localparam logic [DATA_W-1:0] FLASH_BUSY_VAL   = 16'h009b;

    // Sequencer states
    typedef enum logic [1:0] {
        ASR_RUN        = 2'b00,
        ASR_RESET      = 2'b01,
        ASR_HOLD_FLASH = 2'b10,
        ASR_HOLD_EXT   = 2'b11
    } asr_state_e;

endpackage : asr_pkg

// file: asr_filt_if.sv
`timescale 1ns/1ps
`default_nettype none

interface asr_filt_if;
    logic raw_low;
    logic filt_low;

    modport filter (input raw_low, output filt_low);
    modport user   (output raw_low, input filt_low);
endinterface : asr_filt_if

`default_nettype wire

// file: asr_glitch_filter.sv
`timescale 1ns/1ps
`default_nettype none

module asr_glitch_filter #(
    parameter int unsigned STABLE_CYC = asr_pkg::FILT_CYC
) (
    // Clock and reset
    input  wire logic     ref_clk_in,
    input  wire logic     rst_in,
    // Levels
    asr_filt_if.filter    filt
);
    import asr_pkg::*;

    localparam int unsigned CW = $clog2(STABLE_CYC + 1);

    logic [CW-1:0] cnt_q;
    logic          filt_q;
    wire logic     differs = filt.raw_low != filt_q;
    wire logic     settled = cnt_q == CW'(STABLE_CYC - 1);

    // Reset state asserts the request so nothing runs before the pin is seen high
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q  <= '0;
            filt_q <= 1'b1;
        end else if (!differs) begin
            cnt_q  <= '0;
        end else if (settled) begin
            cnt_q  <= '0;
            filt_q <= filt.raw_low;
        end else begin
            cnt_q  <= cnt_q + CW'(1);
        end
    end

    assign filt.filt_low = filt_q;

endmodule : asr_glitch_filter

`default_nettype wire

// file: asr_top.sv
`timescale 1ns/1ps
`default_nettype none

module asr_top #(
    parameter int unsigned FLASH_INIT_CYC  = asr_pkg::FLASH_INIT_CYC,
    parameter int unsigned EXT_RELEASE_TCL = asr_pkg::EXT_TCL_MAX,
    parameter int unsigned FLASH_BLANK_CYC = asr_pkg::FLASH_BLANK_CYC
) (
    // Clock and reset
    input  wire logic                       ref_clk_in,
    input  wire logic                       rst_in,
    // Reset pins
    input  wire logic                       ext_reset_request_n_in,
    input  wire logic                       reset_mode_select_in,
    input  wire logic                       external_boot_select_n_in,
    output logic                            reset_indicator_out_n,
    // Configuration port
    input  wire logic [asr_pkg::CFG_W-1:0]  config_port_in,
    output logic                            config_pullup_out,
    output logic [asr_pkg::CFG_W-1:0]       config_out,
    // Core control
    input  wire logic                       flash_init_done_in,
    output logic                            core_reset_out,
    output logic                            hold_cancel_out,
    output logic                            bus_abort_out,
    output logic                            pin_drive_en_out,
    output logic                            fetch_start_out,
    output logic [asr_pkg::ADDR_W-1:0]      fetch_addr_out,
    // External bus strobes
    input  wire logic                       core_ale_in,
    input  wire logic                       core_rd_n_in,
    input  wire logic                       core_write_strobe_n_in,
    output logic                            ale_out,
    output logic                            rd_n_out,
    output logic                            write_strobe_n_out,
    // Flash read path
    input  wire logic [asr_pkg::DATA_W-1:0] flash_raw_data_in,
    output logic [asr_pkg::DATA_W-1:0]      flash_rd_data_out,
    output logic                            flash_ready_out
);
    import asr_pkg::*;

    localparam int unsigned ICW = $clog2(FLASH_INIT_CYC + 1);
    localparam int unsigned TCW = $clog2(EXT_RELEASE_TCL + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0]       req_sync_q;
    logic [1:0]       mode_sync_q;
    logic [1:0]       boot_sync_q;
    logic [CFG_W-1:0] cfg_meta_q;
    logic [CFG_W-1:0] cfg_sync_q;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_sync_q  <= 2'b00;
            mode_sync_q <= 2'b00;
            boot_sync_q <= 2'b11;
            cfg_meta_q  <= CFG_RESET_VAL;
            cfg_sync_q  <= CFG_RESET_VAL;
        end else begin
            req_sync_q  <= {req_sync_q[0], ext_reset_request_n_in};
            mode_sync_q <= {mode_sync_q[0], reset_mode_select_in};
            boot_sync_q <= {boot_sync_q[0], external_boot_select_n_in};
            cfg_meta_q  <= config_port_in;
            cfg_sync_q  <= cfg_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request filter
    asr_filt_if filt_bus ();

    assign filt_bus.raw_low = ~req_sync_q[1];

    asr_glitch_filter #(
        .STABLE_CYC (FILT_CYC)
    ) u_filter (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .filt       (filt_bus)
    );

    wire logic req_low   = filt_bus.filt_low;
    // Evaluated every cycle, so a mode select that falls mid-request still counts
    wire logic async_req = req_low & ~mode_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    asr_state_e       state_q;
    asr_state_e       state_d;
    logic             boot_ext_q;
    logic             flash_ready_q;
    logic [ICW-1:0]   init_cnt_q;
    logic [TCW-1:0]   tcl_cnt_q;
    logic [CFG_W-1:0] config_q;
    logic             fetch_start_q;

    wire logic in_reset    = state_q == ASR_RESET;
    wire logic init_expire = init_cnt_q == ICW'(FLASH_INIT_CYC - 1);
    wire logic flash_done  = flash_init_done_in | init_expire;
    wire logic tcl_done    = tcl_cnt_q == TCW'(EXT_RELEASE_TCL - 1);
    wire logic leaving     = (state_q != ASR_RUN) && (state_d == ASR_RUN);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ASR_RUN: begin
                if (async_req) begin
                    state_d = ASR_RESET;
                end
            end
            ASR_RESET: begin
                if (!req_low) begin
                    state_d = boot_ext_q ? ASR_HOLD_EXT : ASR_HOLD_FLASH;
                end
            end
            ASR_HOLD_FLASH: begin
                if (req_low) begin
                    state_d = ASR_RESET;
                end else if (flash_ready_q || flash_done) begin
                    state_d = ASR_RUN;
                end
            end
            ASR_HOLD_EXT: begin
                if (req_low) begin
                    state_d = ASR_RESET;
                end else if (tcl_done) begin
                    state_d = ASR_RUN;
                end
            end
        endcase
    end

    // Clockless power-on is covered by rst_in; the pin path needs the clock to filter spikes
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ASR_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Boot source is taken from the pin while reset is held
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            boot_ext_q <= 1'b0;
        end else if (in_reset) begin
            boot_ext_q <= ~boot_sync_q[1];
        end
    end

    // Flash init runs from request release, also behind an external boot
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            init_cnt_q    <= '0;
            flash_ready_q <= 1'b0;
        end else if (in_reset) begin
            init_cnt_q    <= '0;
            flash_ready_q <= 1'b0;
        end else if (!flash_ready_q) begin
            init_cnt_q    <= init_cnt_q + ICW'(1);
            flash_ready_q <= flash_done;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tcl_cnt_q <= '0;
        end else if (state_q == ASR_HOLD_EXT) begin
            tcl_cnt_q <= tcl_cnt_q + TCW'(1);
        end else begin
            tcl_cnt_q <= '0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            config_q      <= CFG_RESET_VAL;
            fetch_start_q <= 1'b0;
        end else begin
            fetch_start_q <= leaving;
            if (leaving) begin
                config_q <= cfg_sync_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reset_indicator_out_n = ~in_reset;
    assign hold_cancel_out       = in_reset;
    assign bus_abort_out         = in_reset;
    assign pin_drive_en_out      = ~in_reset;
    assign config_pullup_out     = in_reset;
    assign core_reset_out        = state_q != ASR_RUN;
    assign config_out            = config_q;
    assign fetch_start_out       = fetch_start_q;
    assign fetch_addr_out        = RESET_FETCH_ADDR;

    // Strobes idle whenever the core is held, so the first cycle after exit is clean
    assign ale_out               = core_reset_out ? 1'b0 : core_ale_in;
    assign rd_n_out              = core_reset_out ? 1'b1 : core_rd_n_in;
    assign write_strobe_n_out    = core_reset_out ? 1'b1 : core_write_strobe_n_in;

    wire logic blank_phase = init_cnt_q < ICW'(FLASH_BLANK_CYC);
    wire logic [DATA_W-1:0] busy_data = blank_phase ? FLASH_BLANK_VAL : FLASH_BUSY_VAL;

    assign flash_ready_out   = flash_ready_q;
    assign flash_rd_data_out = flash_ready_q ? flash_raw_data_in : busy_data;

endmodule : asr_top

`default_nettype wire

// file: asr_notes_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: asr_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module asr_top_checker
    import asr_pkg::*;
(
    // Pins and clock
    input wire logic              ref_clk_in,
    input wire logic              rst_in,
    input wire logic              ext_reset_request_n_in,
    input wire logic              reset_mode_select_in,
    input wire logic              external_boot_select_n_in,
    input wire logic              flash_init_done_in,
    input wire logic [DATA_W-1:0] flash_raw_data_in,
    // Outputs
    input wire logic              reset_indicator_out_n,
    input wire logic              config_pullup_out,
    input wire logic              core_reset_out,
    input wire logic              pin_drive_en_out,
    input wire logic              fetch_start_out,
    input wire logic [ADDR_W-1:0] fetch_addr_out,
    input wire logic              ale_out,
    input wire logic              rd_n_out,
    input wire logic              write_strobe_n_out,
    input wire logic              flash_ready_out,
    input wire logic [DATA_W-1:0] flash_rd_data_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    // Sync plus filter need 5 low samples, and 3 cycles more, before the request counts
    sequence s_req;
        (!ext_reset_request_n_in && !reset_mode_select_in) [*8];
    endsequence
    sequence s_exit;
        core_reset_out ##1 !core_reset_out;
    endsequence
    AST_HELD: assert property (
        !reset_indicator_out_n |-> core_reset_out && !pin_drive_en_out && config_pullup_out)
        else $error("reset outputs wrong");
    AST_ENTER: assert property (s_req |-> ##[0:2] !reset_indicator_out_n)
        else $error("reset entry late");
    AST_FILTER: assert property (
        $fell(reset_indicator_out_n) |-> !$past(ext_reset_request_n_in, 3)
        && !$past(ext_reset_request_n_in, 6)) else $error("short pulse accepted");
    AST_STROBE: assert property (
        core_reset_out |-> !ale_out && rd_n_out && write_strobe_n_out) else $error("strobes");
    AST_FETCH: assert property (
        s_exit |-> fetch_start_out && fetch_addr_out == RESET_FETCH_ADDR) else $error("fetch");
    AST_EXT: assert property (
        $rose(reset_indicator_out_n) && !external_boot_select_n_in
        |-> core_reset_out [*3] ##[1:6] !core_reset_out) else $error("ext release count");
    AST_FLASH_HOLD: assert property (
        reset_indicator_out_n && core_reset_out && external_boot_select_n_in
        && !flash_init_done_in |=> core_reset_out) else $error("core released early");
    AST_FLASH_DATA: assert property (
        flash_ready_out |-> flash_rd_data_out == flash_raw_data_in) else $error("flash data");
endmodule : asr_top_checker
bind asr_top asr_top_checker i_asr_top_checker (
    .ref_clk_in, .rst_in, .ext_reset_request_n_in, .reset_mode_select_in,
    .external_boot_select_n_in, .flash_init_done_in, .flash_raw_data_in, .reset_indicator_out_n,
    .config_pullup_out, .core_reset_out, .pin_drive_en_out, .fetch_start_out, .fetch_addr_out,
    .ale_out, .rd_n_out, .write_strobe_n_out, .flash_ready_out, .flash_rd_data_out);
`default_nettype wire

// file: asr_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module asr_supervisor (
    // Clock
    input  wire logic ref_clk_in,
    // Reset pins
    output logic      req_n_out,
    output logic      mode_out
);
    // Low from power-up until released: covers regulator, oscillator, PLL and config
    initial begin
        req_n_out = 1'b0;
        mode_out = 1'b0;
    end
    // Short calls are deliberate glitches; mode high gives a warm request
    task automatic hold_low(input int cyc, input int fall_at);
        @(negedge ref_clk_in);
        req_n_out = 1'b0;
        mode_out = (fall_at > 0);
        for (int i = 1; i <= cyc; i++) begin
            @(negedge ref_clk_in);
            if (i == fall_at) mode_out = 1'b0;
        end
        // Mode kept as is: dropping it while the filtered request is low turns a warm request async
        req_n_out = 1'b1;
    endtask : hold_low
endmodule : asr_supervisor
`default_nettype wire

// file: tb_async_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_async_reset_sequencer;
    import asr_pkg::*;
    logic              clk, rst, req_n, mode, boot_n, done, ale, rd_n, wr_n, ind_n, pull, core;
    logic              hold, abort, drv, fetch, ready, ale_o, rd_o, wr_o;
    logic [CFG_W-1:0]  cfg, cfg_q;
    logic [DATA_W-1:0] raw, rdata;
    logic [ADDR_W-1:0] faddr;
    int                failures = 0;
    int                total_checks = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Short flash count keeps the internal boot case brief
    asr_top #(.FLASH_INIT_CYC(50)) i_asr_top (
        .ref_clk_in(clk), .rst_in(rst), .ext_reset_request_n_in(req_n),
        .reset_mode_select_in(mode), .external_boot_select_n_in(boot_n),
        .reset_indicator_out_n(ind_n), .config_port_in(cfg), .config_pullup_out(pull),
        .config_out(cfg_q), .flash_init_done_in(done), .core_reset_out(core),
        .hold_cancel_out(hold), .bus_abort_out(abort), .pin_drive_en_out(drv),
        .fetch_start_out(fetch), .fetch_addr_out(faddr), .core_ale_in(ale), .core_rd_n_in(rd_n),
        .core_write_strobe_n_in(wr_n), .ale_out(ale_o), .rd_n_out(rd_o),
        .write_strobe_n_out(wr_o), .flash_raw_data_in(raw), .flash_rd_data_out(rdata),
        .flash_ready_out(ready));
    asr_supervisor i_asr_supervisor (.ref_clk_in(clk), .req_n_out(req_n), .mode_out(mode));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic conclude;
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic wait_lvl(ref logic s, input logic v, output int n);
        for (n = 0; s !== v; n++) begin
            @(negedge clk);
            if (n > 200) begin
                chk(1'b0, "wait timed out");
                conclude();
            end
        end
    endtask : wait_lvl
    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_power_on;
        int n;
        i_asr_supervisor.hold_low(35, 0);
        repeat (20) @(negedge clk);
        chk(core === 1'b1 && ind_n === 1'b1, "core ran before flash init");
        done = 1'b1;
        wait_lvl(core, 1'b0, n);
        chk(cfg_q === 16'h1234, "config not captured");
        chk(fetch === 1'b1 && faddr === RESET_FETCH_ADDR, "no fetch from zero");
        @(negedge clk);
        chk(fetch === 1'b0, "fetch pulse too long");
        chk(ready === 1'b1 && rdata === raw, "flash data not raw");
    endtask : s_power_on
    task automatic s_async;
        int n;
        boot_n = 1'b0;
        done = 1'b0;
        ale = 1'b1;
        rd_n = 1'b0;
        @(negedge clk);
        chk(ale_o === 1'b1 && rd_o === 1'b0 && wr_o === 1'b1, "strobes not passed");
        fork
            i_asr_supervisor.hold_low(55, 0);
        join_none
        wait_lvl(ind_n, 1'b0, n);
        chk(n <= 10, "reset entry late");
        chk(!drv && pull && abort && hold, "not in reset state");
        chk(ale_o === 1'b0 && rd_o === 1'b1 && wr_o === 1'b1, "strobes not idle");
        cfg = 16'hc3a5;
        wait_lvl(ind_n, 1'b1, n);
        wait_lvl(core, 1'b0, n);
        chk(n >= EXT_TCL_MIN && n <= EXT_TCL_MAX, "ext release count");
        chk(cfg_q === 16'hc3a5 && rdata === FLASH_BLANK_VAL, "config or blank");
        repeat (30) @(negedge clk);
        chk(rdata === FLASH_BUSY_VAL, "busy read");
    endtask : s_async
    task automatic s_filter;
        int n;
        i_asr_supervisor.hold_low(3, 0);
        repeat (15) @(negedge clk);
        chk(ind_n === 1'b1, "glitch accepted");
        i_asr_supervisor.hold_low(20, 99);
        // The filtered request stays low a few cycles after the pin rises
        repeat (15) @(negedge clk);
        chk(ind_n === 1'b1, "warm request accepted");
        fork
            i_asr_supervisor.hold_low(55, 10);
        join_none
        wait_lvl(ind_n, 1'b0, n);
        chk(n >= 10 && n <= 20, "late mode fall ignored");
        wait_lvl(core, 1'b0, n);
    endtask : s_filter
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, boot_n, done, ale, rd_n, wr_n} = 6'h33;
        cfg = 16'h1234;
        raw = 16'h5a5a;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        s_power_on();
        s_async();
        s_filter();
        conclude();
    end
endmodule : tb_async_reset_sequencer
`default_nettype wire
